/* design/seq_cfg_pkg.sv */
// Constants, device register map and decode helpers for the demodulator
// configuration controller. Assumes a 40 MHz core clock.
package seq_cfg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 40_000_000;
  localparam int SETTLE_US    = 100;
  // Least time, so round up
  localparam int SETTLE_CYC   = (SETTLE_US * (CLK_HZ / 1_000_000) * 1_000 + 999) / 1_000;
  localparam int SPI_HALF_CYC = 4;
  localparam int FRAME_BITS   = 24;

  // ----------------------------------------------------------------
  // Serial frame fields
  // ----------------------------------------------------------------
  localparam logic       RW_WRITE = 1'h0;
  localparam logic       RW_READ  = 1'h1;

  // ----------------------------------------------------------------
  // Device register addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] DA_INIT     = 7'h7F;
  localparam logic [6:0] DA_R6       = 7'h06;
  localparam logic [6:0] DA_CLKGATE  = 7'h02;
  localparam logic [6:0] DA_LOMODE   = 7'h51;
  localparam logic [6:0] DA_EXTDIV   = 7'h52;
  localparam logic [6:0] DA_CALCTL   = 7'h7E;
  localparam logic [6:0] DA_PHASE    = 7'h5F;
  localparam logic [6:0] DA_GAIN     = 7'h5E;
  localparam logic [6:0] DA_CMODE    = 7'h53;
  localparam logic [6:0] DA_SIGCHAIN = 7'h4F;
  localparam logic [6:0] DA_IFBIAS   = 7'h58;
  localparam logic [6:0] DA_OCDIV    = 7'h70;
  localparam logic [6:0] DA_OCEN     = 7'h71;
  localparam logic [6:0] DA_INTDIV   = 7'h72;

  // ----------------------------------------------------------------
  // Device data values and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] INIT_UNLOCK = 16'h0003;
  localparam logic [15:0] R6_VALUE    = 16'h0100;
  localparam logic [15:0] INIT_LOCK   = 16'h0000;
  localparam int          GATE_BIT    = 10;
  localparam int          SEL_BIT     = 0;
  localparam int          DIVEN_LSB   = 6;
  localparam logic [1:0]  DIVEN_ON    = 2'h3;
  localparam int          FSMRST_BIT  = 8;
  localparam int          RANGE_BIT   = 15;
  localparam int          PHPOL_BIT   = 15;
  localparam int          PHMAG_LSB   = 9;
  localparam int          QGAIN_LSB   = 8;
  localparam int          VCM_LSB     = 9;
  localparam int          PULL_LSB    = 13;
  localparam int          PUEN_BIT    = 6;
  localparam int          LOPATH_LSB  = 12;
  localparam logic [2:0]  LOPATH_POLY = 3'h7;
  localparam int          OC_I_BIT    = 0;
  localparam int          OC_Q_BIT    = 1;

  // ----------------------------------------------------------------
  // Avalon word offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] A_CTRL   = 3'h0;
  localparam logic [2:0] A_STATUS = 3'h1;
  localparam logic [2:0] A_CLKCFG = 3'h2;
  localparam logic [2:0] A_TRIM   = 3'h3;
  localparam logic [2:0] A_CMCFG  = 3'h4;
  localparam logic [2:0] A_RAW    = 3'h5;
  localparam logic [2:0] A_RDBACK = 3'h6;
  localparam logic [2:0] A_DIVSTA = 3'h7;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] prescale_div(input logic [2:0] code);
    case (code)
      3'h0:    prescale_div = 5'h01;
      3'h1:    prescale_div = 5'h02;
      3'h3:    prescale_div = 5'h04;
      3'h7:    prescale_div = 5'h08;
      default: prescale_div = 5'h10;
    endcase
  endfunction

  // {pullup enable, pullup strength, bias config} per common-mode level
  function automatic logic [5:0] cm_pairing(input logic [2:0] level);
    case (level)
      3'h0:    cm_pairing = {1'h1, 3'h7, 2'h0};
      3'h1:    cm_pairing = {1'h1, 3'h3, 2'h0};
      3'h2:    cm_pairing = {1'h1, 3'h1, 2'h0};
      3'h3:    cm_pairing = {1'h0, 3'h0, 2'h0};
      default: cm_pairing = {1'h0, 3'h0, 2'h3};
    endcase
  endfunction

endpackage

/* design/spi_frame_master.sv */
// Shifts one 24-bit frame MSB first to the device, capturing readback.
// Assumes miso is already synchronised to core_clk.
`timescale 1ns/1ps
module spi_frame_master
  import seq_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Frame request
  input  wire logic        go,
  input  wire logic [23:0] tx,
  output logic             busy,
  output logic             done,
  output logic [15:0]      rx,
  // Serial pins
  output logic             sck,
  output logic             csb_n,
  output logic             mosi,
  input  wire logic        miso
);

  logic [23:0] sh_r;
  logic [7:0]  cnt_r;
  logic [4:0]  bit_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy  <= 1'h0;
      done  <= 1'h0;
      rx    <= 16'h0000;
      sck   <= 1'h0;
      csb_n <= 1'h1;
      mosi  <= 1'h0;
      sh_r  <= 24'h000000;
      cnt_r <= 8'h00;
      bit_r <= 5'h00;
    end else begin
      done <= 1'h0;
      if (!busy) begin
        if (go) begin
          // Select falls while sck is low
          busy  <= 1'h1;
          csb_n <= 1'h0;
          sh_r  <= tx;
          mosi  <= tx[23];
          cnt_r <= 8'h00;
          bit_r <= 5'h00;
        end
      end else if (cnt_r == 8'(SPI_HALF_CYC - 1)) begin
        cnt_r <= 8'h00;
        if (!sck) begin
          if (bit_r == 5'(FRAME_BITS)) begin
            busy  <= 1'h0;
            csb_n <= 1'h1;
            done  <= 1'h1;
          end else begin
            sck <= 1'h1;
          end
        end else begin
          // Sample late in the high half to absorb synchroniser delay
          sck   <= 1'h0;
          rx    <= {rx[14:0], miso};
          sh_r  <= {sh_r[22:0], 1'h0};
          mosi  <= sh_r[22];
          bit_r <= bit_r + 5'h01;
        end
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

endmodule // spi_frame_master

/* design/wait_timer.sv */
// One-shot cycle counter; done pulses count cycles after go.
// Assumes count is at least one.
`timescale 1ns/1ps
module wait_timer (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        go,
  input  wire logic [15:0] count,
  output logic             done
);

  logic [15:0] cnt_r;
  logic        run_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
      run_r <= 1'h0;
      done  <= 1'h0;
    end else begin
      done <= 1'h0;
      if (go) begin
        cnt_r <= count;
        run_r <= 1'h1;
      end else if (run_r) begin
        if (cnt_r <= 16'h0001) begin
          run_r <= 1'h0;
          done  <= 1'h1;
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end

endmodule // wait_timer

/* design/seq_cfg_ctrl.sv */
// Host controller: brings up the demodulator over its serial port,
// runs the clock and offset-correction flow, then loads trims.
// Assumes an Avalon-MM master on core_clk and async device pins.
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module seq_cfg_ctrl
  import seq_cfg_pkg::*;
#(
  parameter logic [15:0] CAL_WAIT_CYC = 16'h9C40
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Device serial port
  output logic             spi_sck,
  output logic             spi_csb_n,
  output logic             spi_sdo,
  input  wire logic        spi_sdi,
  // Device status and sync
  input  wire logic        lock_detect,
  input  wire logic        ext_lo_valid,
  output logic             phase_sync
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [24:0] {
    S_IDLE   = 25'h0000001, S_INIT0  = 25'h0000002, S_INIT1  = 25'h0000004,
    S_INIT2  = 25'h0000008, S_MODE   = 25'h0000010, S_CLKON  = 25'h0000020,
    S_INTDIV = 25'h0000040, S_WLOCK  = 25'h0000080, S_EXTDIV = 25'h0000100,
    S_WEXT   = 25'h0000200, S_DIVEN  = 25'h0000400, S_SELX   = 25'h0000800,
    S_SETTLE = 25'h0001000, S_CALDIV = 25'h0002000, S_FSMR1  = 25'h0004000,
    S_FSMR0  = 25'h0008000, S_CALEN  = 25'h0010000, S_WCAL   = 25'h0020000,
    S_CLKOFF = 25'h0040000, S_PH     = 25'h0080000, S_GN     = 25'h0100000,
    S_CM     = 25'h0200000, S_PU     = 25'h0400000, S_BIAS   = 25'h0800000,
    S_RAW    = 25'h1000000
  } seq_state_e;

  seq_state_e  state_r;
  seq_state_e  state_nxt;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic        ext_mode_r;
  logic        poly_r;
  logic        sync_r;
  logic        start_r;
  logic        raw_go_r;
  logic        done_r;
  logic [3:0]  int_exp_r;
  logic [5:0]  ext_div_r;
  logic [7:0]  oc_div_r;
  logic [5:0]  ph_mag_r;
  logic        ph_pol_r;
  logic        ph_range_r;
  logic [7:0]  i_gain_r;
  logic [7:0]  q_gain_r;
  logic [3:0]  vcm_sel_r;
  logic [2:0]  cm_level_r;
  logic [23:0] raw_frame_r;
  logic        rd_ack_r;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0]  pin_in;
  logic [2:0]  meta_r;
  logic [2:0]  pin_s;

  assign pin_in = {spi_sdi, lock_detect, ext_lo_valid};

  generate
    for (genvar g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[g] <= 1'h0;
          pin_s[g]  <= 1'h0;
        end else begin
          meta_r[g] <= pin_in[g];
          pin_s[g]  <= meta_r[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Frame builder and sequencing
  // ----------------------------------------------------------------
  logic        is_frame;
  logic        is_timed;
  logic [6:0]  fr_addr;
  logic [15:0] fr_data;
  logic        fr_read;
  logic        issued_r;
  logic        spi_go;
  logic        spi_busy;
  logic        spi_done;
  logic [15:0] spi_rx;
  logic        tmr_done;
  logic        advance;
  logic [5:0]  cm_pair;
  logic [15:0] lomode_base;

  assign cm_pair     = cm_pairing(cm_level_r);
  assign lomode_base = 16'(ext_mode_r) << SEL_BIT;

  always_comb begin
    is_frame  = 1'h1;
    is_timed  = 1'h0;
    fr_read   = RW_WRITE;
    fr_addr   = DA_INIT;
    fr_data   = 16'h0000;
    state_nxt = S_IDLE;
    case (state_r)
      S_INIT0: begin
        fr_data   = INIT_UNLOCK;
        state_nxt = S_INIT1;
      end
      S_INIT1: begin
        fr_addr   = DA_R6;
        fr_data   = R6_VALUE;
        state_nxt = S_INIT2;
      end
      S_INIT2: begin
        fr_data   = INIT_LOCK;
        state_nxt = S_MODE;
      end
      S_MODE: begin
        // Select and enable stay low until the external path is proven
        fr_addr   = DA_LOMODE;
        state_nxt = ext_mode_r ? S_EXTDIV : S_CLKON;
      end
      S_CLKON: begin
        fr_addr   = DA_CLKGATE;
        fr_data   = 16'h0001 << GATE_BIT;
        state_nxt = S_INTDIV;
      end
      S_INTDIV: begin
        fr_addr   = DA_INTDIV;
        fr_data   = 16'(int_exp_r);
        state_nxt = S_WLOCK;
      end
      S_WLOCK: begin
        is_frame  = 1'h0;
        state_nxt = S_CALDIV;
      end
      S_EXTDIV: begin
        fr_addr   = DA_EXTDIV;
        fr_data   = 16'(ext_div_r);
        state_nxt = S_WEXT;
      end
      S_WEXT: begin
        is_frame  = 1'h0;
        state_nxt = S_DIVEN;
      end
      S_DIVEN: begin
        fr_addr   = DA_LOMODE;
        fr_data   = 16'(DIVEN_ON) << DIVEN_LSB;
        state_nxt = S_SELX;
      end
      S_SELX: begin
        fr_addr   = DA_LOMODE;
        fr_data   = (16'(DIVEN_ON) << DIVEN_LSB) | (16'h0001 << SEL_BIT);
        state_nxt = S_SETTLE;
      end
      S_SETTLE: begin
        is_frame  = 1'h0;
        is_timed  = 1'h1;
        state_nxt = S_CALDIV;
      end
      S_CALDIV: begin
        fr_addr   = DA_OCDIV;
        fr_data   = 16'(oc_div_r);
        state_nxt = S_FSMR1;
      end
      S_FSMR1: begin
        fr_addr   = DA_CALCTL;
        fr_data   = (16'(ph_range_r) << RANGE_BIT) | (16'h0001 << FSMRST_BIT);
        state_nxt = S_FSMR0;
      end
      S_FSMR0: begin
        fr_addr   = DA_CALCTL;
        fr_data   = 16'(ph_range_r) << RANGE_BIT;
        state_nxt = S_CALEN;
      end
      S_CALEN: begin
        fr_addr   = DA_OCEN;
        fr_data   = (16'h0001 << OC_I_BIT) | (16'h0001 << OC_Q_BIT);
        state_nxt = S_WCAL;
      end
      S_WCAL: begin
        is_frame  = 1'h0;
        is_timed  = 1'h1;
        state_nxt = S_CLKOFF;
      end
      S_CLKOFF: begin
        // Clock left running couples spurs into the IF path
        fr_addr   = ext_mode_r ? DA_LOMODE : DA_CLKGATE;
        fr_data   = ext_mode_r ? lomode_base : 16'h0000;
        state_nxt = S_PH;
      end
      S_PH: begin
        fr_addr   = DA_PHASE;
        fr_data   = (16'(ph_pol_r) << PHPOL_BIT) | (16'(ph_mag_r) << PHMAG_LSB);
        state_nxt = S_GN;
      end
      S_GN: begin
        fr_addr   = DA_GAIN;
        fr_data   = (16'(q_gain_r) << QGAIN_LSB) | 16'(i_gain_r);
        state_nxt = S_CM;
      end
      S_CM: begin
        fr_addr   = DA_CMODE;
        fr_data   = (16'(cm_pair[4:2]) << PULL_LSB) | (16'(vcm_sel_r) << VCM_LSB);
        state_nxt = S_PU;
      end
      S_PU: begin
        fr_addr   = DA_SIGCHAIN;
        fr_data   = (16'(ext_mode_r | poly_r) * 16'(LOPATH_POLY) << LOPATH_LSB)
                  | (16'(cm_pair[5]) << PUEN_BIT);
        state_nxt = S_BIAS;
      end
      S_BIAS: begin
        fr_addr   = DA_IFBIAS;
        fr_data   = 16'(cm_pair[1:0]);
      end
      S_RAW: begin
        fr_read   = raw_frame_r[23];
        fr_addr   = raw_frame_r[22:16];
        fr_data   = raw_frame_r[15:0];
      end
      default: begin
        is_frame  = 1'h0;
        state_nxt = S_IDLE;
      end
    endcase
  end

  assign spi_go  = is_frame & ~issued_r & ~spi_busy;
  assign advance = spi_done | tmr_done
                 | ((state_r == S_WLOCK) & pin_s[1])
                 | ((state_r == S_WEXT) & pin_s[0]);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      issued_r <= 1'h0;
    end else if (advance) begin
      issued_r <= 1'h0;
    end else if (spi_go || (is_timed && !issued_r)) begin
      issued_r <= 1'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
    end else if (state_r == S_IDLE) begin
      if (start_r) begin
        state_r <= S_INIT0;
      end else if (raw_go_r) begin
        state_r <= S_RAW;
      end
    end else if (advance) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'h0;
    end else if (advance && state_r == S_BIAS) begin
      done_r <= 1'h1;
    end else if (start_r) begin
      done_r <= 1'h0;
    end
  end

  spi_frame_master u_spi (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .go       (spi_go),
    .tx       ({fr_read, fr_addr, fr_data}),
    .busy     (spi_busy),
    .done     (spi_done),
    .rx       (spi_rx),
    .sck      (spi_sck),
    .csb_n    (spi_csb_n),
    .mosi     (spi_sdo),
    .miso     (pin_s[2])
  );

  wait_timer u_tmr (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .go       (is_timed & ~issued_r),
    .count    ((state_r == S_SETTLE) ? 16'(SETTLE_CYC) : CAL_WAIT_CYC),
    .done     (tmr_done)
  );

  // ----------------------------------------------------------------
  // Divide-ratio report
  // ----------------------------------------------------------------
  logic [15:0] seq_ratio;

  assign seq_ratio = ext_mode_r
    ? (16'(prescale_div(ext_div_r[5:3])) << ext_div_r[2:0])
    : (16'h0001 << int_exp_r);

  // ----------------------------------------------------------------
  // Avalon register access
  // ----------------------------------------------------------------
  assign avs_waitrequest = avs_read & ~rd_ack_r;
  assign phase_sync      = sync_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_mode_r  <= 1'h0;
      poly_r      <= 1'h0;
      sync_r      <= 1'h0;
      start_r     <= 1'h0;
      raw_go_r    <= 1'h0;
      int_exp_r   <= 4'h0;
      ext_div_r   <= 6'h00;
      oc_div_r    <= 8'h01;
      ph_mag_r    <= 6'h00;
      ph_pol_r    <= 1'h0;
      ph_range_r  <= 1'h0;
      i_gain_r    <= 8'h80;
      q_gain_r    <= 8'h80;
      vcm_sel_r   <= 4'h0;
      cm_level_r  <= 3'h3;
      raw_frame_r <= 24'h000000;
    end else begin
      start_r  <= 1'h0;
      raw_go_r <= 1'h0;
      if (avs_write) begin
        case (avs_address)
          A_CTRL: begin
            // Mode bits and start requests only take while idle; sync and the other registers take at any time
            start_r  <= avs_writedata[0] & (state_r == S_IDLE);
            raw_go_r <= avs_writedata[3] & (state_r == S_IDLE);
            sync_r   <= avs_writedata[4];
            if (state_r == S_IDLE) begin
              ext_mode_r <= avs_writedata[1];
              poly_r     <= avs_writedata[2];
            end
          end
          A_CLKCFG: begin
            int_exp_r <= avs_writedata[3:0];
            ext_div_r <= avs_writedata[9:4];
            oc_div_r  <= avs_writedata[23:16];
          end
          A_TRIM: begin
            ph_mag_r   <= avs_writedata[5:0];
            ph_pol_r   <= avs_writedata[6];
            ph_range_r <= avs_writedata[7];
            i_gain_r   <= avs_writedata[15:8];
            q_gain_r   <= avs_writedata[23:16];
          end
          A_CMCFG: begin
            vcm_sel_r  <= avs_writedata[3:0];
            cm_level_r <= avs_writedata[6:4];
          end
          A_RAW: begin
            raw_frame_r <= avs_writedata[23:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ack_r     <= 1'h0;
      avs_readdata <= 32'h00000000;
    end else begin
      rd_ack_r <= avs_read & ~rd_ack_r;
      if (avs_read && !rd_ack_r) begin
        case (avs_address)
          A_CTRL:   avs_readdata <= {27'h0, sync_r, 1'h0, poly_r, ext_mode_r, 1'h0};
          A_STATUS: avs_readdata <= {22'h0, pin_s[0], pin_s[1], 6'h0,
                                     done_r, (state_r != S_IDLE)};
          A_CLKCFG: avs_readdata <= {8'h0, oc_div_r, 6'h0, ext_div_r, int_exp_r};
          A_TRIM:   avs_readdata <= {8'h0, q_gain_r, i_gain_r, ph_range_r, ph_pol_r,
                                     ph_mag_r};
          A_CMCFG:  avs_readdata <= {25'h0, cm_level_r, vcm_sel_r};
          A_RAW:    avs_readdata <= {8'h0, raw_frame_r};
          A_RDBACK: avs_readdata <= {16'h0, spi_rx};
          A_DIVSTA: avs_readdata <= {16'h0, seq_ratio};
          default:  avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // seq_cfg_ctrl

/* test/seq_cfg_ctrl_assertions.sv */
// Checks serial frame timing and Avalon answer timing of seq_cfg_ctrl.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
module seq_cfg_ctrl_assertions (
  // Clock, reset and bus
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Serial pins
  input wire logic spi_sck,
  input wire logic spi_csb_n,
  input wire logic spi_sdo
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] bits_r;
  // Counts rising sck edges inside one frame
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) bits_r <= 5'h00;
    else if ($fell(spi_csb_n)) bits_r <= 5'h00;
    else if ($rose(spi_sck)) bits_r <= bits_r + 5'h01;
  sequence hi_half; spi_sck [*4] ##1 !spi_sck; endsequence
  sequence lo_half; !spi_sck [*4]; endsequence
  sck_high_time_a: assert property ($rose(spi_sck) |-> hi_half)
    else $error("sck high time wrong");
  sck_low_time_a: assert property ($fell(spi_sck) |-> lo_half)
    else $error("sck low time wrong");
  select_sck_low_a: assert property ($fell(spi_csb_n) |-> !spi_sck)
    else $error("select fell with sck high");
  idle_sck_low_a: assert property (spi_csb_n |-> !spi_sck)
    else $error("sck moved while idle");
  data_stable_a: assert property ($rose(spi_sck) |-> $stable(spi_sdo))
    else $error("data moved at sck rise");
  frame_length_a: assert property ($rose(spi_csb_n) |-> bits_r == 5'h18)
    else $error("frame not 24 bits");
  frame_gap_a: assert property ($rose(spi_csb_n) |=> spi_csb_n)
    else $error("no gap between frames");
  read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer timing wrong");
  write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
endmodule // seq_cfg_ctrl_assertions

bind seq_cfg_ctrl seq_cfg_ctrl_assertions seq_cfg_ctrl_assertions_inst (
  .core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .spi_sck(spi_sck), .spi_csb_n(spi_csb_n),
  .spi_sdo(spi_sdo));

/* test/dev_model.sv */
// Behavioural demodulator: takes 24-bit frames, holds registers, reports lock.
// Assumes the controller keeps select high between frames.
`timescale 1ns/1ps
module dev_model (
  // Serial pins
  input  wire logic        sck,
  input  wire logic        csb_n,
  input  wire logic        sdi,
  output logic             sdo,
  // Lock and bench view
  output logic             lock,
  output logic [23:0]      frame,
  output logic             got
);
  logic [15:0] regs [128];
  logic [23:0] sh_r = 24'h000000;
  initial {sdo, lock, got, frame} = '0;
  // Clock pulses ignored while deselected
  always @(posedge sck) if (!csb_n) sh_r <= {sh_r[22:0], sdi};
  // Readback unused; keep the line moving so no stale level passes
  always @(negedge sck) sdo <= ~sdo;
  always @(posedge csb_n) begin
    frame = sh_r;
    got = 1'b1;
    if (!sh_r[23]) regs[sh_r[22:16]] = sh_r[15:0];
    #1 got = 1'b0;
    // Relock takes a while after the divider changes
    if (sh_r[22:16] == 7'h72) begin
      lock = 1'b0;
      #2000 lock = 1'b1;
    end
  end
endmodule // dev_model

/* test/seq_cfg_ctrl_tb.sv */
// Self-checking bench for seq_cfg_ctrl with a device model on the serial port.
// Assumes a 40 MHz clock and a shortened correction wait.
`timescale 1ns/1ps
module seq_cfg_ctrl_tb;
  import seq_cfg_pkg::*;
  logic        core_clk = 0, rst_n = 0, rd = 0, wr = 0, ext_ok = 0;
  logic [2:0]  adr = 3'h0;
  logic [31:0] wd = 32'h0, rdat, rq[$];
  logic        wreq, sck, csb_n, sdo, sdi, lock, got, psync;
  logic [23:0] frame, fq[$];
  int          err_total = 0, tests_run = 0;
  always #12.5 core_clk = ~core_clk;
  seq_cfg_ctrl #(.CAL_WAIT_CYC(16'h0014)) seq_cfg_ctrl_inst (.core_clk(core_clk),
    .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .spi_sck(sck), .spi_csb_n(csb_n),
    .spi_sdo(sdo), .spi_sdi(sdi), .lock_detect(lock), .ext_lo_valid(ext_ok),
    .phase_sync(psync));
  dev_model dev_model_inst (.sck(sck), .csb_n(csb_n), .sdi(sdo), .sdo(sdi), .lock(lock),
    .frame(frame), .got(got));
  task automatic finish_test();
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic fail(string m);
    $display("ERROR %0t %s", $time, m);
    err_total++;
  endtask
  task automatic cmp_frame(logic [23:0] g, logic [23:0] e);
    tests_run++;
    if (g !== e) fail("frame mismatch");
  endtask
  task automatic cmp_read(logic [31:0] g, logic [31:0] e);
    tests_run++;
    if (g !== e) fail("read mismatch");
  endtask
  task automatic bus(logic w, logic [2:0] a, logic [31:0] d);
    int n;
    @(posedge core_clk);
    {adr, wd, wr, rd} <= {a, d, w, !w};
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (wreq === 1'b0) break;
    end
    {wr, rd} <= 2'h0;
    if (n == 50) begin fail("bus timeout"); finish_test(); end
  endtask
  // Starts a flow, waits for done, then checks status and that every frame came
  task automatic run_seq(logic [31:0] c, logic [31:0] s);
    int k;
    bus(1, A_CTRL, c);
    for (k = 0; k < 800; k++) begin
      bus(0, A_STATUS, 0);
      if (rdat[1] === 1'b1) break;
      repeat (20) @(posedge core_clk);
    end
    if (k == 800) begin fail("done timeout"); finish_test(); end
    rq.push_back(s);
    bus(0, A_STATUS, 0);
    cmp_read(32'(fq.size()), 32'h0);
  endtask
  // Oscillator only appears once the divider has been set
  always @(posedge got) if (frame[22:16] == DA_EXTDIV) ext_ok <= 1'b1;
  always @(posedge got) if (fq.size() > 0) cmp_frame(frame, fq.pop_front());
  always @(posedge core_clk) if (rd && wreq === 1'b0 && rq.size() > 0) cmp_read(rdat, rq.pop_front());
  initial begin
    logic [3:0] ex, v;
    logic [5:0] m, ed;
    logic [15:0] g;
    int k;
    void'($urandom(32'hd629a5dc));
    ex = 4'($urandom_range(7, 1));
    m = 6'($urandom);
    g = 16'($urandom);
    ed = 6'($urandom);
    v = 4'($urandom);
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    // External ratio: prescale times two to the binary code
    bus(1, A_CTRL, 32'h2);
    for (k = 0; k < 8; k++) begin
      bus(1, A_CLKCFG, {16'h000A, 6'h0, 3'(k), 3'h1, 4'h0});
      rq.push_back((k == 0 ? 1 : k == 1 ? 2 : k == 3 ? 4 : k == 7 ? 8 : 16) * 2);
      bus(0, A_DIVSTA, 0);
    end
    bus(1, A_CTRL, 32'h0);
    bus(1, A_CLKCFG, {16'h000A, 12'h0, ex});
    rq.push_back(32'h1 << ex);
    bus(0, A_DIVSTA, 0);
    bus(1, A_TRIM, {8'h0, g, 2'h1, m});
    bus(1, A_CMCFG, {25'h0, 3'h0, v});
    fq = '{24'h7F0003, 24'h060100, 24'h7F0000, 24'h510000, 24'h020400, {20'h72000, ex},
           24'h70000A, 24'h7E0100, 24'h7E0000, 24'h710003, 24'h020000,
           {8'h5F, 1'b1, m, 9'h0}, {8'h5E, g}, {8'h53, 3'h7, v, 9'h0}, 24'h4F0040,
           24'h580000};
    run_seq(32'h1, 32'h102);
    // External flow: divider, valid oscillator, enable, select, settle
    bus(1, A_CLKCFG, {16'h000A, 6'h0, ed, 4'h0});
    bus(1, A_CMCFG, {25'h0, 3'h4, v});
    fq = '{24'h7F0003, 24'h060100, 24'h7F0000, 24'h510000, {8'h52, 10'h0, ed}, 24'h5100C0,
           24'h5100C1, 24'h70000A, 24'h7E0100, 24'h7E0000, 24'h710003, 24'h510001,
           {8'h5F, 1'b1, m, 9'h0}, {8'h5E, g}, {8'h53, 3'h0, v, 9'h0}, 24'h4F7000,
           24'h580003};
    run_seq(32'h3, 32'h302);
    // Raw frame goes out unchanged, then sync pin follows its bit
    fq.push_back({1'b0, 23'($urandom)});
    bus(1, A_RAW, {8'h0, fq[0]});
    bus(1, A_CTRL, 32'h8);
    for (k = 0; k < 400 && fq.size() > 0; k++) @(posedge core_clk);
    if (fq.size() > 0) begin fail("frame timeout"); finish_test(); end
    bus(1, A_CTRL, 32'h10);
    @(posedge core_clk);
    cmp_read({31'h0, psync}, 32'h1);
    finish_test();
  end
endmodule // seq_cfg_ctrl_tb
